// ==== rtl/offset_adder.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "seg_addr_map.svh"
module offset_adder (
  input  wire logic [15:0] disp,
  input  wire logic        disp_is_byte,
  input  wire logic        use_disp,
  input  wire logic [15:0] base,
  input  wire logic        use_base,
  input  wire logic [15:0] index,
  input  wire logic        use_index,
  output var  logic [15:0] offset
);
  wire [15:0] disp_ext;
  wire [15:0] term_d;
  wire [15:0] term_b;
  wire [15:0] term_i;
  assign disp_ext = disp_is_byte ?
    {{(`OFS_W-`DISP8_W){disp[`DISP8_W-1]}}, disp[`DISP8_W-1:0]} : disp;
  assign term_d = use_disp  ? disp_ext : `OFS_ZERO;
  assign term_b = use_base  ? base     : `OFS_ZERO;
  assign term_i = use_index ? index    : `OFS_ZERO;
  assign offset = 16'(term_d + term_b + term_i);
endmodule // offset_adder
`default_nettype wire

// ==== rtl/seg_addr_map.svh ====
`ifndef SEG_ADDR_MAP_SVH
`define SEG_ADDR_MAP_SVH
`define OFS_W      16
`define PHYS_W     20
`define SEG_SHIFT  4
`define DISP8_W    8
`define SEG_CODE   2'h0
`define SEG_DATA   2'h1
`define SEG_STACK  2'h2
`define SEG_EXTRA  2'h3
`define OFS_ZERO   16'h0000
`define PHYS_ZERO  20'h00000
`endif

// ==== rtl/seg_addr_pkg.sv ====
`default_nettype none
package seg_addr_pkg;
  typedef enum logic [3:0] {
    mode_register        = 4'h0,
    mode_immediate       = 4'h1,
    mode_direct          = 4'h2,
    mode_reg_indirect    = 4'h3,
    mode_based           = 4'h4,
    mode_indexed         = 4'h5,
    mode_based_indexed   = 4'h6,
    mode_based_idx_disp  = 4'h7,
    mode_stack           = 4'h8,
    mode_fetch           = 4'h9,
    mode_string_dst      = 4'hA,
    mode_pointer_load    = 4'hB
  } addr_mode_e;
  typedef enum logic [1:0] {
    seg_code = 2'h0, seg_data = 2'h1, seg_stack = 2'h2, seg_extra = 2'h3
  } seg_sel_e;
  typedef struct packed {
    addr_mode_e  mode;
    logic        base_is_frame;
    logic        index_is_dest;
    logic        disp_is_byte;
    logic [15:0] disp;
    logic        override_valid;
    seg_sel_e    override_seg;
    logic        valid;
  } addr_req_s;
  typedef struct packed {
    logic [15:0] code_seg;
    logic [15:0] data_segment_base;
    logic [15:0] stack_seg;
    logic [15:0] extra_segment_base;
    logic [15:0] general_base_register;
    logic [15:0] frame_base_pointer;
    logic [15:0] source_index;
    logic [15:0] destination_index_register;
    logic [15:0] stack_ptr;
    logic [15:0] instr_ptr;
  } reg_view_s;
  typedef struct packed {
    logic        valid;
    logic        mem_ref;
    seg_sel_e    seg;
    logic [15:0] seg_base;
    logic [15:0] offset;
    logic [19:0] phys;
    logic [15:0] operand;
    logic        operand_valid;
    logic        load_pointer;
  } addr_out_s;
endpackage
`default_nettype wire

// ==== rtl/seg_select.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "seg_addr_map.svh"
module seg_select (
  input  wire seg_addr_pkg::addr_req_s req,
  output var  seg_addr_pkg::seg_sel_e  seg
);
  wire seg_addr_pkg::seg_sel_e implicit_seg;
  wire uses_frame;
  assign uses_frame = req.base_is_frame &&
    ((req.mode == seg_addr_pkg::mode_reg_indirect && !req.index_is_dest) ||
     req.mode == seg_addr_pkg::mode_based ||
     req.mode == seg_addr_pkg::mode_based_indexed ||
     req.mode == seg_addr_pkg::mode_based_idx_disp);
  assign implicit_seg =
    (req.mode == seg_addr_pkg::mode_fetch ||
     req.mode == seg_addr_pkg::mode_immediate) ? seg_addr_pkg::seg_code :
    (req.mode == seg_addr_pkg::mode_stack || uses_frame) ?
      seg_addr_pkg::seg_stack :
    (req.mode == seg_addr_pkg::mode_string_dst) ? seg_addr_pkg::seg_extra :
    seg_addr_pkg::seg_data;
  assign seg = (req.override_valid &&
                req.mode != seg_addr_pkg::mode_fetch &&
                req.mode != seg_addr_pkg::mode_immediate &&
                req.mode != seg_addr_pkg::mode_stack &&
                req.mode != seg_addr_pkg::mode_string_dst) ?
               req.override_seg : implicit_seg;
endmodule // seg_select
`default_nettype wire

// ==== rtl/segmented_address_generator.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "seg_addr_map.svh"
module segmented_address_generator (
  input  wire logic                       clock,
  input  wire logic                       rst_n,
  input  wire seg_addr_pkg::addr_req_s    req,
  input  wire seg_addr_pkg::reg_view_s    regs,
  input  wire logic [15:0]                gen_operand,
  output var  seg_addr_pkg::addr_out_s    result
);
  logic rst_meta;
  logic rst_sync;
  wire  rst_n_int;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end
  assign rst_n_int = rst_sync;

  // Mode decode
  wire m_reg, m_imm, m_dir, m_ind, m_bas, m_idx, m_bi, m_bid;
  wire m_stk, m_fet, m_str, m_ptr;
  assign m_reg = req.mode == seg_addr_pkg::mode_register;
  assign m_imm = req.mode == seg_addr_pkg::mode_immediate;
  assign m_dir = req.mode == seg_addr_pkg::mode_direct;
  assign m_ind = req.mode == seg_addr_pkg::mode_reg_indirect;
  assign m_bas = req.mode == seg_addr_pkg::mode_based;
  assign m_idx = req.mode == seg_addr_pkg::mode_indexed;
  assign m_bi  = req.mode == seg_addr_pkg::mode_based_indexed;
  assign m_bid = req.mode == seg_addr_pkg::mode_based_idx_disp;
  assign m_stk = req.mode == seg_addr_pkg::mode_stack;
  assign m_fet = req.mode == seg_addr_pkg::mode_fetch;
  assign m_str = req.mode == seg_addr_pkg::mode_string_dst;
  assign m_ptr = req.mode == seg_addr_pkg::mode_pointer_load;

  // Register indirect: index_is_dest picks an index, else base_is_frame
  // picks between the two bases; base_is_frame high with an index selects
  // the destination index.
  wire ind_uses_index;
  assign ind_uses_index = m_ind & req.index_is_dest;

  wire use_disp, use_base, use_index;
  assign use_disp  = m_dir | m_bas | m_idx | m_bid | m_ptr;
  assign use_base  = m_bas | m_bi | m_bid | (m_ind & ~req.index_is_dest);
  assign use_index = m_idx | m_bi | m_bid | m_str | ind_uses_index;

  wire [15:0] base_val;
  wire [15:0] index_val;
  wire        pick_dest_index;
  assign base_val  = req.base_is_frame ? regs.frame_base_pointer :
                                         regs.general_base_register;
  assign pick_dest_index = m_str |
                           (ind_uses_index ? req.base_is_frame :
                                             req.index_is_dest);
  assign index_val = pick_dest_index ?
                     regs.destination_index_register : regs.source_index;

  wire [15:0] ea;
  offset_adder u_ofs (
    .disp         (req.disp),
    .disp_is_byte (req.disp_is_byte),
    .use_disp     (use_disp),
    .base         (base_val),
    .use_base     (use_base),
    .index        (index_val),
    .use_index    (use_index),
    .offset       (ea)
  );

  wire seg_addr_pkg::seg_sel_e seg;
  seg_select u_seg (
    .req (req),
    .seg (seg)
  );

  // segment base from one of four
  wire [15:0] seg_base;
  assign seg_base = (seg == seg_addr_pkg::seg_code)  ? regs.code_seg :
                    (seg == seg_addr_pkg::seg_stack) ? regs.stack_seg :
                    (seg == seg_addr_pkg::seg_extra) ?
                      regs.extra_segment_base : regs.data_segment_base;

  wire [15:0] offset;
  assign offset = m_fet ? regs.instr_ptr :
                  m_stk ? regs.stack_ptr :
                  m_imm ? regs.instr_ptr : ea;

  wire [19:0] phys;
  assign phys = 20'({seg_base, {`SEG_SHIFT{1'b0}}} + {4'h0, offset});

  wire mem_ref;
  assign mem_ref = req.valid & ~m_reg;

  wire [15:0] operand;
  wire        operand_valid;
  assign operand       = m_reg ? gen_operand : req.disp;
  assign operand_valid = req.valid & (m_reg | m_imm);

  seg_addr_pkg::addr_out_s next_result;
  always_comb begin
    next_result               = '0;
    next_result.valid         = req.valid;
    next_result.mem_ref       = mem_ref & ~m_imm;
    next_result.seg           = seg;
    next_result.seg_base      = mem_ref ? seg_base : `OFS_ZERO;
    next_result.offset        = mem_ref ? offset : `OFS_ZERO;
    next_result.phys          = mem_ref ? phys : `PHYS_ZERO;
    next_result.operand       = operand;
    next_result.operand_valid = operand_valid;
    next_result.load_pointer  = req.valid & m_ptr;
  end

  always_ff @(posedge clock or negedge rst_n_int) begin
    if (!rst_n_int) begin
      result <= '0;
    end else begin
      result <= next_result;
    end
  end

  logic [15:0] last_seg_base;
  logic [15:0] last_offset;
  always_ff @(posedge clock or negedge rst_n_int) begin
    if (!rst_n_int) begin
      last_seg_base <= `OFS_ZERO;
      last_offset   <= `OFS_ZERO;
    end else begin
      last_seg_base <= next_result.seg_base;
      last_offset   <= next_result.offset;
    end
  end

  property p_phys_sum;
    @(posedge clock) disable iff (!rst_n_int)
    result.mem_ref |->
      result.phys == 20'({last_seg_base, 4'h0} + {4'h0, last_offset});
  endproperty
  a_phys_sum: assert property (p_phys_sum)
    else $error("physical address mismatch");

  property p_reg_no_mem;
    @(posedge clock) disable iff (!rst_n_int)
    (req.valid && m_reg) |=> (!result.mem_ref && result.operand_valid);
  endproperty
  a_reg_no_mem: assert property (p_reg_no_mem)
    else $error("register mode made a memory reference");

  property p_imm_operand;
    @(posedge clock) disable iff (!rst_n_int)
    (req.valid && m_imm) |=> result.operand == $past(req.disp);
  endproperty
  a_imm_operand: assert property (p_imm_operand)
    else $error("immediate operand wrong");

  property p_fetch_code;
    @(posedge clock) disable iff (!rst_n_int)
    (req.valid && m_fet) |=> result.seg == seg_addr_pkg::seg_code;
  endproperty
  a_fetch_code: assert property (p_fetch_code)
    else $error("fetch not in code segment");

  property p_stack_seg;
    @(posedge clock) disable iff (!rst_n_int)
    (req.valid && !req.override_valid &&
     (m_stk || ((m_bas || m_bi) && req.base_is_frame)))
      |=> result.seg == seg_addr_pkg::seg_stack;
  endproperty
  a_stack_seg: assert property (p_stack_seg)
    else $error("stack reference not in stack segment");

  property p_string_extra;
    @(posedge clock) disable iff (!rst_n_int)
    (req.valid && m_str) |=> result.seg == seg_addr_pkg::seg_extra;
  endproperty
  a_string_extra: assert property (p_string_extra)
    else $error("string destination not in extra segment");

  property p_override;
    @(posedge clock) disable iff (!rst_n_int)
    (req.valid && req.override_valid && m_dir)
      |=> result.seg == $past(req.override_seg);
  endproperty
  a_override: assert property (p_override)
    else $error("override prefix ignored");

  property p_direct_sext;
    @(posedge clock) disable iff (!rst_n_int)
    (req.valid && m_dir && req.disp_is_byte)
      |=> result.offset == {{8{$past(req.disp[7])}}, $past(req.disp[7:0])};
  endproperty
  a_direct_sext: assert property (p_direct_sext)
    else $error("byte displacement not sign extended");

  property p_bi_sum;
    @(posedge clock) disable iff (!rst_n_int)
    (req.valid && m_bi)
      |=> result.offset == 16'($past(base_val) + $past(index_val));
  endproperty
  a_bi_sum: assert property (p_bi_sum)
    else $error("based indexed offset wrong");

  property p_ptr_load;
    @(posedge clock) disable iff (!rst_n_int)
    (req.valid && m_ptr) |=> (result.load_pointer && result.mem_ref);
  endproperty
  a_ptr_load: assert property (p_ptr_load)
    else $error("pointer load not flagged");

  property p_answer_next;
    @(posedge clock) disable iff (!rst_n_int)
    1'b1 |=> result.valid == $past(req.valid);
  endproperty
  a_answer_next: assert property (p_answer_next)
    else $error("answer not one cycle after request");

  property p_direct_word;
    @(posedge clock) disable iff (!rst_n_int)
    (req.valid && m_dir && !req.disp_is_byte)
      |=> result.offset == $past(req.disp);
  endproperty
  a_direct_word: assert property (p_direct_word)
    else $error("direct offset is not the displacement");

  property p_data_base;
    @(posedge clock) disable iff (!rst_n_int)
    (req.valid && m_dir && !req.override_valid)
      |=> result.seg_base == $past(regs.data_segment_base);
  endproperty
  a_data_base: assert property (p_data_base)
    else $error("segment base not from the data segment");

  property p_data_seg;
    @(posedge clock) disable iff (!rst_n_int)
    (req.valid && !req.override_valid && (m_dir || m_idx || m_ptr))
      |=> result.seg == seg_addr_pkg::seg_data;
  endproperty
  a_data_seg: assert property (p_data_seg)
    else $error("plain data reference not in data segment");

  property p_indirect_index;
    @(posedge clock) disable iff (!rst_n_int)
    (req.valid && m_ind && req.index_is_dest)
      |=> result.offset == ($past(req.base_is_frame) ?
                            $past(regs.destination_index_register) :
                            $past(regs.source_index));
  endproperty
  a_indirect_index: assert property (p_indirect_index)
    else $error("register indirect index offset wrong");

  property p_based_wrap;
    @(posedge clock) disable iff (!rst_n_int)
    (req.valid && m_bas && !req.disp_is_byte && !req.base_is_frame &&
     !req.override_valid)
      |=> result.phys == 20'({$past(regs.data_segment_base), 4'h0} +
                             {4'h0, 16'($past(req.disp) +
                                  $past(regs.general_base_register))});
  endproperty
  a_based_wrap: assert property (p_based_wrap)
    else $error("offset carry reached the physical address");

  property p_indexed_sum;
    @(posedge clock) disable iff (!rst_n_int)
    (req.valid && m_idx && !req.disp_is_byte && !req.index_is_dest)
      |=> result.offset == 16'($past(req.disp) + $past(regs.source_index));
  endproperty
  a_indexed_sum: assert property (p_indexed_sum)
    else $error("indexed offset wrong");

  property p_bid_sum;
    @(posedge clock) disable iff (!rst_n_int)
    (req.valid && m_bid && !req.disp_is_byte &&
     !req.base_is_frame && !req.index_is_dest)
      |=> result.offset == 16'($past(req.disp) +
                               $past(regs.general_base_register) +
                               $past(regs.source_index));
  endproperty
  a_bid_sum: assert property (p_bid_sum)
    else $error("based indexed displacement offset wrong");
endmodule // segmented_address_generator
`default_nettype wire

// ==== tb/reg_file_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module reg_file_model (
  output var seg_addr_pkg::reg_view_s regs,
  output var logic [15:0]             gen_operand
);
  // Fixed contents; general base near the top so offset sums carry out
  assign regs = '{code_seg: 16'h1000, data_segment_base: 16'h2000,
                  stack_seg: 16'h3000, extra_segment_base: 16'h4000,
                  general_base_register: 16'hFFF0,
                  frame_base_pointer: 16'h0100, source_index: 16'h0020,
                  destination_index_register: 16'h0300,
                  stack_ptr: 16'h0FFE, instr_ptr: 16'h0040};
  assign gen_operand = 16'hBEEF;
endmodule // reg_file_model
`default_nettype wire

// ==== tb/segmented_address_generator_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module segmented_address_generator_bench;
  logic                      clock;
  logic                      rst_n;
  logic                      live;
  int                        err_count;
  int                        checks_done;
  seg_addr_pkg::addr_req_s   req;
  seg_addr_pkg::addr_req_s   seen_req;
  seg_addr_pkg::reg_view_s   regs;
  logic [15:0]               gen_operand;
  seg_addr_pkg::addr_out_s   result;
  seg_addr_pkg::addr_out_s   want;

  reg_file_model far_side (.regs(regs), .gen_operand(gen_operand));
  segmented_address_generator DUT (.clock(clock), .rst_n(rst_n),
    .req(req), .regs(regs), .gen_operand(gen_operand), .result(result));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic print_verdict();
    if (err_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  function automatic seg_addr_pkg::addr_req_s mk(input logic [3:0] m,
    input logic bf, input logic xd, input logic db, input logic [15:0] d,
    input logic ov, input logic [1:0] os);
    mk = '{mode: seg_addr_pkg::addr_mode_e'(m), base_is_frame: bf,
           index_is_dest: xd, disp_is_byte: db, disp: d,
           override_valid: ov, override_seg: seg_addr_pkg::seg_sel_e'(os),
           valid: 1'b1};
  endfunction

  // Expected answer worked out from the addressing and segment rules
  function automatic seg_addr_pkg::addr_out_s model(
    input seg_addr_pkg::addr_req_s r);
    logic [15:0] d, b, x, o, sb;
    logic [1:0]  s;
    logic [3:0]  m;
    model = '0;
    m = r.mode;
    d = r.disp_is_byte ? {{8{r.disp[7]}}, r.disp[7:0]} : r.disp;
    b = r.base_is_frame ? regs.frame_base_pointer
                        : regs.general_base_register;
    x = r.index_is_dest ? regs.destination_index_register
                        : regs.source_index;
    case (m)
      4'h2, 4'hB: o = d;
      4'h3: o = !r.index_is_dest ? b :
                r.base_is_frame ? regs.destination_index_register :
                                  regs.source_index;
      4'h4: o = d + b;
      4'h5: o = d + x;
      4'h6: o = b + x;
      4'h7: o = b + x + d;
      4'h8: o = regs.stack_ptr;
      4'h9: o = regs.instr_ptr;
      4'hA: o = regs.destination_index_register;
      default: o = 16'h0000;
    endcase
    if (m == 4'h1 || m == 4'h9) s = 2'h0;
    else if (m == 4'h8) s = 2'h2;
    else if (m == 4'hA) s = 2'h3;
    else if (r.override_valid) s = r.override_seg;
    else if (r.base_is_frame && (m inside {4'h4, 4'h6, 4'h7} ||
             (m == 4'h3 && !r.index_is_dest))) s = 2'h2;
    else s = 2'h1;
    case (s)
      2'h0: sb = regs.code_seg;
      2'h1: sb = regs.data_segment_base;
      2'h2: sb = regs.stack_seg;
      default: sb = regs.extra_segment_base;
    endcase
    model.valid = r.valid;
    model.mem_ref = (m > 4'h1);
    model.seg = seg_addr_pkg::seg_sel_e'(s);
    model.seg_base = sb;
    model.offset = o;
    model.phys = (m == 4'h0) ? 20'h00000 : {sb, 4'h0} + {4'h0, o};
    model.operand = (m == 4'h0) ? gen_operand : r.disp;
    model.operand_valid = r.valid && (m == 4'h0 || m == 4'h1);
    model.load_pointer = (m == 4'hB);
  endfunction

  // Each answer is judged one edge after its request was sampled
  always @(posedge clock) seen_req <= req;
  always @(negedge clock) begin
    if (live) begin
      want = model(seen_req);
      check(20'(result.valid), 20'(want.valid));
      if (seen_req.valid === 1'b1) begin
        check(20'(result.mem_ref), 20'(want.mem_ref));
        check(20'(result.load_pointer), 20'(want.load_pointer));
        check(20'(result.operand_valid), 20'(want.operand_valid));
        if (want.mem_ref) begin
          check(20'(result.seg), 20'(want.seg));
          check(20'(result.seg_base), 20'(want.seg_base));
          check(20'(result.offset), 20'(want.offset));
          check(result.phys, want.phys);
        end else begin
          check(20'(result.operand), 20'(want.operand));
          if (seen_req.mode == 4'h0) check(result.phys, want.phys);
        end
      end
    end
  end

  task automatic send(input seg_addr_pkg::addr_req_s r);
    @(posedge clock);
    req <= r;
  endtask

  task automatic settle();
    @(posedge clock);
    req <= '0;
    repeat (3) @(posedge clock);
  endtask

  task automatic t_direct();
    send(mk(4'h2, 1'b0, 1'b0, 1'b0, 16'h1234, 1'b0, 2'h0));
    send(mk(4'h2, 1'b0, 1'b0, 1'b1, 16'h3380, 1'b0, 2'h0));
    send(mk(4'hB, 1'b0, 1'b0, 1'b0, 16'h0500, 1'b0, 2'h0));
    settle();
  endtask

  task automatic t_indirect();
    send(mk(4'h3, 1'b0, 1'b0, 1'b0, 16'h7777, 1'b0, 2'h0));
    send(mk(4'h3, 1'b1, 1'b0, 1'b0, 16'h7777, 1'b0, 2'h0));
    send(mk(4'h3, 1'b0, 1'b1, 1'b0, 16'h7777, 1'b0, 2'h0));
    send(mk(4'h3, 1'b1, 1'b1, 1'b0, 16'h7777, 1'b0, 2'h0));
    settle();
  endtask

  task automatic t_combos();
    for (int i = 4; i < 8; i++)
      for (int j = 0; j < 4; j++)
        send(mk(i[3:0], j[0], j[0], j[1], 16'h12A0, 1'b0, 2'h0));
    settle();
  endtask

  task automatic t_override();
    for (int i = 0; i < 4; i++) begin
      send(mk(4'h4, 1'b0, 1'b0, 1'b0, 16'h0010, 1'b1, i[1:0]));
      send(mk(4'h7, 1'b1, 1'b1, 1'b1, 16'h00F0, 1'b1, i[1:0]));
    end
    settle();
  endtask

  task automatic t_implicit();
    send(mk(4'h8, 1'b0, 1'b0, 1'b0, 16'h0000, 1'b1, 2'h1));
    send(mk(4'h9, 1'b0, 1'b0, 1'b0, 16'h0000, 1'b1, 2'h1));
    send(mk(4'hA, 1'b0, 1'b1, 1'b0, 16'h0000, 1'b1, 2'h0));
    settle();
  endtask

  task automatic t_operands();
    send(mk(4'h0, 1'b0, 1'b0, 1'b0, 16'h1111, 1'b0, 2'h0));
    send(mk(4'h1, 1'b0, 1'b0, 1'b0, 16'h5A5A, 1'b0, 2'h0));
    settle();
  endtask

  // Mid-run reset clears the answer at once
  task automatic t_reset();
    send(mk(4'h4, 1'b1, 1'b0, 1'b0, 16'h0044, 1'b0, 2'h0));
    @(posedge clock);
    live  <= 1'b0;
    rst_n <= 1'b0;
    req   <= '0;
    @(negedge clock);
    check(20'(result.valid), 20'h00000);
    check(result.phys, 20'h00000);
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    live <= 1'b1;
    send(mk(4'h5, 1'b0, 1'b1, 1'b0, 16'h0044, 1'b0, 2'h0));
    settle();
  endtask

  initial begin
    rst_n = 1'b0;
    live = 1'b0;
    err_count = 0;
    checks_done = 0;
    req = '0;
    repeat (11) @(posedge clock);
    check(20'(result.valid), 20'h00000);
    check(result.phys, 20'h00000);
    @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    live <= 1'b1;
    t_direct();
    t_indirect();
    t_combos();
    t_override();
    t_implicit();
    t_operands();
    t_reset();
    print_verdict();
  end

  initial begin
    repeat (2000) @(posedge clock);
    err_count++;
    print_verdict();
  end
endmodule // segmented_address_generator_bench
`default_nettype wire
